// [xosc_ctrl.sv]
// Crystal oscillator state control, stability counter and control register
`timescale 1ns/1ps

module xosc_ctrl
  import xosc_pkg::*;
#(
  parameter int STABLE_CYCLES = XOSC_STABLE_CYCLES
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic osc_gen_enable,
  input wire logic ext_ref_select,
  input wire logic cfg_high_range,
  input wire logic cfg_low_power,
  input wire logic rtc_osc_override,
  input wire logic [3:0] rtc_cap_select,
  input wire logic run_mode,
  input wire logic stop_mode,
  input wire logic deep_stop_wake,
  input wire logic gpio_alt_select,
  input wire logic crystal_input_pin,
  output logic crystal_output_pin_out,
  output logic crystal_output_pin_oe_n,
  output logic pins_connected,
  output logic min_current,
  output logic osc_high_range,
  output logic osc_low_power,
  output logic [3:0] load_cap_select_bits,
  output logic system_osc_clock,
  output logic peripheral_ref_clock,
  output logic low_range_peripheral_clock,
  output logic stable_count_done
);

  localparam logic [XOSC_CNT_WIDTH-1:0] CNT_LAST =
    XOSC_CNT_WIDTH'(STABLE_CYCLES - 1);

  // ----------------------------------------------------------------
  // Control register and read port
  // ----------------------------------------------------------------
  logic [7:0] ctrl;
  logic [7:0] next_ctrl;
  logic [7:0] next_rdata;
  xosc_state_t state;
  xosc_state_t next_state;

  // Deep-stop wake beats a write in the same cycle
  always_comb begin
    next_ctrl = ctrl;
    if (deep_stop_wake) begin
      next_ctrl = XOSC_CTRL_RESET;
    end else if (reg_write && reg_addr == XOSC_CTRL_OFFSET) begin
      next_ctrl = reg_wdata & XOSC_CTRL_WMASK;
    end
    next_rdata = 8'h00;
    if (reg_read && reg_addr == XOSC_CTRL_OFFSET) begin
      next_rdata = ctrl;
    end else if (reg_read && reg_addr == XOSC_STATUS_OFFSET) begin
      next_rdata = {4'h0, rtc_osc_override, stable_count_done, state};
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ctrl <= XOSC_CTRL_RESET;
      reg_rdata <= 8'h00;
    end else begin
      ctrl <= next_ctrl;
      reg_rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Effective enables
  // ----------------------------------------------------------------
  logic ext_ref_clock_enable;
  logic ext_ref_stop_enable;
  logic osc_enable;
  logic sel_internal;
  assign ext_ref_clock_enable = ctrl[XOSC_EXT_REF_CLOCK_ENABLE_BIT];
  assign ext_ref_stop_enable = ctrl[XOSC_EXT_REF_STOP_ENABLE_BIT];

  // Override wins over every enable and the source select
  always_comb begin
    if (rtc_osc_override) begin
      osc_enable = 1'b1;
    end else if (stop_mode) begin
      osc_enable = ext_ref_clock_enable & ext_ref_stop_enable;
    end else begin
      osc_enable = osc_gen_enable | ext_ref_clock_enable;
    end
    sel_internal = rtc_osc_override | ext_ref_select;
  end

  // ----------------------------------------------------------------
  // Raw clock, stability counter and state
  // ----------------------------------------------------------------
  logic raw_clk;
  logic raw_prev;
  logic next_raw;
  logic raw_rise;
  logic [XOSC_CNT_WIDTH-1:0] cnt;
  logic [XOSC_CNT_WIDTH-1:0] next_cnt;
  logic next_done;

  assign raw_rise = raw_clk & ~raw_prev;

  always_comb begin
    // Off with internal source: raw clock parked low
    if (state == XOSC_OFF && sel_internal) begin
      next_raw = 1'b0;
    end else begin
      next_raw = crystal_input_pin;
    end
    next_cnt = cnt;
    next_done = stable_count_done;
    if (!osc_enable || !sel_internal) begin
      next_cnt = '0;
      next_done = 1'b0;
    end else if (state == XOSC_STARTUP && raw_rise && !stable_count_done) begin
      if (cnt == CNT_LAST) begin
        next_done = 1'b1;
      end else begin
        next_cnt = cnt + 1'b1;
      end
    end
    // State choice uses the held count-done level
    if (!osc_enable) begin
      next_state = XOSC_OFF;
    end else if (!sel_internal) begin
      next_state = XOSC_EXTCLK;
    end else if (stable_count_done) begin
      next_state = XOSC_STABLE;
    end else begin
      next_state = XOSC_STARTUP;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      raw_clk <= 1'b0;
      raw_prev <= 1'b0;
      cnt <= '0;
      stable_count_done <= 1'b0;
      state <= XOSC_OFF;
    end else begin
      raw_clk <= next_raw;
      raw_prev <= raw_clk;
      cnt <= next_cnt;
      stable_count_done <= next_done;
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Output gate and clock outputs
  // ----------------------------------------------------------------
  logic gate_open;
  logic next_gate;
  logic gate_want;
  logic gated_next;
  logic [3:0] next_caps;

  always_comb begin
    gate_want = (state == XOSC_EXTCLK) ||
                (state == XOSC_STABLE && stable_count_done);
    // Switching only with raw low avoids runt pulses downstream
    next_gate = raw_clk ? gate_open : gate_want;
    // Startup blanks the output outright; a switch from the external
    // source may therefore cut its last pulse short
    gated_next = next_raw & next_gate & (state != XOSC_STARTUP);
    next_caps = rtc_osc_override ? rtc_cap_select :
                ctrl[XOSC_CAP_WIDTH-1:0];
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      gate_open <= 1'b0;
      system_osc_clock <= 1'b0;
      peripheral_ref_clock <= 1'b0;
      low_range_peripheral_clock <= 1'b0;
      load_cap_select_bits <= 4'h0;
      osc_high_range <= 1'b0;
      osc_low_power <= 1'b0;
    end else begin
      gate_open <= next_gate;
      // System clock is run-only; the other two survive low power
      system_osc_clock <= gated_next & run_mode;
      peripheral_ref_clock <= gated_next & ext_ref_clock_enable &
        (~stop_mode | ext_ref_stop_enable | rtc_osc_override);
      low_range_peripheral_clock <= gated_next &
        (rtc_osc_override | ~cfg_high_range);
      load_cap_select_bits <= next_caps;
      // Range and power are re-registered from the config inputs every cycle; override forces low range, low power
      osc_high_range <= cfg_high_range & ~rtc_osc_override;
      osc_low_power <= cfg_low_power | rtc_osc_override;
    end
  end

  // ----------------------------------------------------------------
  // Pin connection and current control
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      crystal_output_pin_out <= 1'b0;
      crystal_output_pin_oe_n <= 1'b1;
      pins_connected <= 1'b0;
      min_current <= 1'b1;
    end else begin
      // Amplifier drives the output pin only for crystal operation
      crystal_output_pin_out <= ~next_raw;
      crystal_output_pin_oe_n <= ~(next_state == XOSC_STARTUP ||
        next_state == XOSC_STABLE) | (gpio_alt_select &
        next_state == XOSC_EXTCLK);
      pins_connected <= next_state != XOSC_OFF;
      min_current <= next_state == XOSC_OFF;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_startup_held;
    state == XOSC_STARTUP && osc_enable && sel_internal;
  endsequence

  a_off_raw_static: assert property (
    @(posedge mclk) disable iff (!rstn)
    state == XOSC_OFF && sel_internal |=> !raw_clk)
    else $error("raw clock moved in off state");
  a_startup_gated: assert property (
    @(posedge mclk) disable iff (!rstn)
    state == XOSC_STARTUP |=> !system_osc_clock && !peripheral_ref_clock)
    else $error("clock leaked during startup");
  a_done_to_stable: assert property (
    @(posedge mclk) disable iff (!rstn)
    s_startup_held ##0 stable_count_done |=> state == XOSC_STABLE)
    else $error("no stable state after count done");
  a_ext_state: assert property (
    @(posedge mclk) disable iff (!rstn)
    osc_enable && !sel_internal |=> state == XOSC_EXTCLK)
    else $error("external state not entered");
  a_ext_forward: assert property (
    @(posedge mclk) disable iff (!rstn)
    state == XOSC_EXTCLK && gate_open && run_mode
    |=> system_osc_clock == $past(next_raw))
    else $error("external clock not forwarded");
  a_enter_startup: assert property (
    @(posedge mclk) disable iff (!rstn)
    osc_enable && sel_internal && !stable_count_done
    |=> state == XOSC_STARTUP)
    else $error("startup not entered");
  a_count_clear: assert property (
    @(posedge mclk) disable iff (!rstn)
    !osc_enable |=> cnt == '0 && !stable_count_done)
    else $error("counter not cleared");
  a_done_holds: assert property (
    @(posedge mclk) disable iff (!rstn)
    stable_count_done && osc_enable && sel_internal
    |=> stable_count_done)
    else $error("count done dropped early");
  a_gate_low_raw: assert property (
    @(posedge mclk) disable iff (!rstn)
    $changed(gate_open) |-> !$past(raw_clk))
    else $error("gate switched with raw high");
  a_cap_override: assert property (
    @(posedge mclk) disable iff (!rstn)
    rtc_osc_override |=> load_cap_select_bits == $past(rtc_cap_select))
    else $error("override caps not used");
  a_cap_control: assert property (
    @(posedge mclk) disable iff (!rstn)
    !rtc_osc_override
    |=> {4'h0, load_cap_select_bits} == ($past(ctrl) & 8'h0F))
    else $error("register caps not used");
  a_override_lp: assert property (
    @(posedge mclk) disable iff (!rstn)
    rtc_osc_override |=> osc_low_power && !osc_high_range)
    else $error("override did not force low power");
  a_wake_reset: assert property (
    @(posedge mclk) disable iff (!rstn)
    deep_stop_wake |=> ctrl == XOSC_CTRL_RESET)
    else $error("wake did not reset register");
  a_off_min_cur: assert property (
    @(posedge mclk) disable iff (!rstn)
    !osc_enable |=> min_current && !pins_connected)
    else $error("off state not decoupled");

endmodule

// [xosc_pkg.sv]
// Shared constants for the crystal oscillator state control block
package xosc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] XOSC_CTRL_OFFSET = 8'h00;
  localparam logic [7:0] XOSC_STATUS_OFFSET = 8'h04;
  localparam logic [7:0] XOSC_CTRL_RESET = 8'h00;
  // Writable bits; bits 6 and 4 are reserved and read zero
  localparam logic [7:0] XOSC_CTRL_WMASK = 8'hAF;

  // ----------------------------------------------------------------
  // Field positions of oscillator_control
  // ----------------------------------------------------------------
  localparam int XOSC_EXT_REF_CLOCK_ENABLE_BIT = 7;
  localparam int XOSC_EXT_REF_STOP_ENABLE_BIT = 5;
  localparam int XOSC_LOAD_CAP_2PF_BIT = 3;
  localparam int XOSC_LOAD_CAP_4PF_BIT = 2;
  localparam int XOSC_LOAD_CAP_8PF_BIT = 1;
  localparam int XOSC_LOAD_CAP_16PF_BIT = 0;
  localparam int XOSC_CAP_WIDTH = 4;

  // ----------------------------------------------------------------
  // Timing: raw crystal cycles before the clock counts as stable
  // ----------------------------------------------------------------
  localparam int XOSC_STABLE_CYCLES = 4096;
  localparam int XOSC_CNT_WIDTH = 13;

  // ----------------------------------------------------------------
  // Oscillator states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    XOSC_OFF = 2'b00,
    XOSC_STARTUP = 2'b01,
    XOSC_STABLE = 2'b10,
    XOSC_EXTCLK = 2'b11
  } xosc_state_t;

endpackage

// [xosc_crystal_model.sv]
// Crystal or external clock source seen at the oscillator pins
`timescale 1ns/1ps
module xosc_crystal_model #(
  parameter int HALF_NS = 137
) (
  input wire logic run,
  output logic pin
);
  // ----------------------------------------
  // Oscillation
  // ----------------------------------------
  // Unrelated to mclk; parks low while run is low
  initial begin
    pin = 1'b0;
    forever begin
      #(HALF_NS);
      pin = run ? ~pin : 1'b0;
    end
  end
endmodule

// [test_crystal_osc_state_control.sv]
// Self-checking bench for the crystal oscillator state control
`timescale 1ns/1ps
module test_crystal_osc_state_control;
  import xosc_pkg::*;
  logic mclk, rstn, reg_write, reg_read, gen_en, sel, hr, lp, ovr;
  logic run_m, stop_m, wake, galt, pin, oe_n, conn, minc, o_hr, o_lp;
  logic sys_c, per_c, low_c, done, s, p, l, xo, x, ext_src;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd, d;
  logic [3:0] rcap, cap;
  logic [31:0] lfsr;
  int error_cnt, n_compared, e_sys, e_per, e_low, e_xo, i, bad;

  xosc_ctrl #(.STABLE_CYCLES(8)) i_dut (.mclk(mclk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .osc_gen_enable(gen_en),
    .ext_ref_select(sel), .cfg_high_range(hr), .cfg_low_power(lp),
    .rtc_osc_override(ovr), .rtc_cap_select(rcap), .run_mode(run_m),
    .stop_mode(stop_m), .deep_stop_wake(wake), .gpio_alt_select(galt),
    .crystal_input_pin(pin), .crystal_output_pin_out(xo),
    .crystal_output_pin_oe_n(oe_n), .pins_connected(conn),
    .min_current(minc), .osc_high_range(o_hr), .osc_low_power(o_lp),
    .load_cap_select_bits(cap), .system_osc_clock(sys_c),
    .peripheral_ref_clock(per_c), .low_range_peripheral_clock(low_c),
    .stable_count_done(done));

  // An external source keeps running whether or not the pins are coupled
  xosc_crystal_model i_crystal_output_pin (.run(conn | ext_src), .pin(pin));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Strobes drop at the taking edge so the next access may follow
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge mclk);
    reg_write <= 1'b0;
  endtask

  task automatic rdreg(input logic [7:0] a, output logic [7:0] v);
    @(posedge mclk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_read <= 1'b0;
    #1;
    v = reg_rdata;
  endtask

  task automatic cfg(input logic g, input logic x, input logic r);
    @(posedge mclk);
    gen_en <= g;
    sel <= x;
    run_m <= r;
  endtask

  // Counts output toggles over n cycles after one settling cycle
  task automatic watch(input int n);
    e_sys = 0;
    e_per = 0;
    e_low = 0;
    e_xo = 0;
    @(posedge mclk);
    #1;
    repeat (n) begin
      s = sys_c;
      p = per_c;
      l = low_c;
      x = xo;
      @(posedge mclk);
      #1;
      e_sys += int'(sys_c !== s);
      e_per += int'(per_c !== p);
      e_low += int'(low_c !== l);
      e_xo += int'(xo !== x);
    end
  endtask

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    // Range and power stay fixed for the whole run
    {reg_write, reg_read, gen_en, sel, hr, lp, ovr, stop_m} = '0;
    {wake, galt, ext_src, reg_addr, reg_wdata, rcap} = '0;
    run_m = 1'b1;
    lfsr = 32'hA21B4182;
    error_cnt = 0;
    n_compared = 0;
    rstn = 1'b0;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    rdreg(XOSC_CTRL_OFFSET, rd);
    check(rd, XOSC_CTRL_RESET);
    // All ones first, then random control words
    for (i = 0; i < 7; i++) begin
      lfsr = lfsr_next(lfsr);
      d = (i == 0) ? 8'hFF : lfsr[7:0];
      wr(XOSC_CTRL_OFFSET, d);
      rdreg(XOSC_CTRL_OFFSET, rd);
      check(rd, d & XOSC_CTRL_WMASK);
      check({4'h0, cap}, {4'h0, d[3:0]});
    end
    wr(8'h08, 8'h55);
    rdreg(8'h08, rd);
    check(rd, 8'h00);
    // Override takes caps and forces low range, low power
    @(posedge mclk);
    ovr <= 1'b1;
    rcap <= lfsr[11:8];
    repeat (3) @(posedge mclk);
    #1;
    check({4'h0, cap}, {4'h0, lfsr[11:8]});
    check({6'h0, o_lp, o_hr}, 8'h02);
    @(posedge mclk);
    ovr <= 1'b0;
    wake <= 1'b1;
    @(posedge mclk);
    wake <= 1'b0;
    rdreg(XOSC_CTRL_OFFSET, rd);
    check(rd, 8'h00);
    // Off with a live source on the input pin: parked unless external
    @(posedge mclk);
    ext_src <= 1'b1;
    sel <= 1'b1;
    watch(40);
    check({6'h0, conn, minc}, 8'h01);
    check(8'(e_sys), 8'h00);
    check(8'(e_xo), 8'h00);
    @(posedge mclk);
    sel <= 1'b0;
    watch(40);
    check({7'h0, e_xo > 0}, 8'h01);
    // Startup: gated until the count completes
    wr(XOSC_CTRL_OFFSET, 8'h80);
    cfg(1'b1, 1'b1, 1'b1);
    rdreg(XOSC_CTRL_OFFSET + 8'h04, rd);
    check({6'h0, rd[1:0]}, 8'h01);
    bad = 0;
    i = 0;
    while (done !== 1'b1 && i < 3000) begin
      @(posedge mclk);
      #1;
      bad += int'(sys_c !== 1'b0 && done !== 1'b1);
      i++;
    end
    if (i >= 3000) begin
      error_cnt++;
      conclude();
    end
    check(8'(bad), 8'h00);
    rdreg(XOSC_CTRL_OFFSET + 8'h04, rd);
    check({5'h0, rd[2:0]}, 8'h06);
    check({5'h0, oe_n, conn, minc}, 8'h02);
    cfg(1'b1, 1'b1, 1'b0);
    watch(200);
    check({5'h0, e_sys > 0, e_per > 0, e_low > 0}, 8'h03);
    check({7'h0, e_xo > 0}, 8'h01);
    // Stop without stop-enable turns off and clears the count
    @(posedge mclk);
    stop_m <= 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    check({6'h0, conn, done}, 8'h00);
    wr(XOSC_CTRL_OFFSET, 8'hA0);
    rdreg(XOSC_CTRL_OFFSET + 8'h04, rd);
    check({6'h0, rd[1:0]}, 8'h01);
    // External clock passes at once, output pin freed
    @(posedge mclk);
    stop_m <= 1'b0;
    galt <= 1'b1;
    cfg(1'b1, 1'b0, 1'b1);
    rdreg(XOSC_CTRL_OFFSET + 8'h04, rd);
    check({6'h0, rd[1:0]}, 8'h03);
    watch(60);
    check({7'h0, e_sys > 0}, 8'h01);
    check({7'h0, oe_n}, 8'h01);
    conclude();
  end
endmodule
